// File: pdef_gpio.sv
`timescale 1ns/100ps
`include "pdef_consts.svh"

module pdef_gpio (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`PDEF_ADDR_W-1:0] bus_addr,
  input wire logic [`PDEF_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`PDEF_DATA_W-1:0] bus_rdata,
  input wire pdef_pkg::pdef_periph_t periph,
  input wire logic [`PDEF_FIRST_W-1:0] first_pin_in,
  input wire logic [`PDEF_SECOND_W-1:0] second_pin_in,
  input wire logic [`PDEF_THIRD_W-1:0] third_pin_in,
  output pdef_pkg::pdef_pad8_t first_pad,
  output pdef_pkg::pdef_pad6_t second_pad,
  output pdef_pkg::pdef_pad8_t third_pad
);

  // read mux shared by all three data locations
  function automatic logic [7:0] read_mix(
    input logic [7:0] dir,
    input logic [7:0] latch,
    input logic [7:0] pin
  );
    read_mix = (dir & latch) | (~dir & pin);
  endfunction

  // a timer channel owns its pin when its two select bits are not both zero
  function automatic logic [3:0] tim_owned(input logic [7:0] sel);
    logic [3:0] own;
    own = 4'h0;
    for (int i = 0; i < 4; i++) begin
      own[i] = |sel[2*i +: 2];
    end
    tim_owned = own;
  endfunction

  // register state
  logic [7:0] first_port_data_ff, nxt_first_port_data;
  logic [5:0] second_port_data_ff, nxt_second_port_data;
  logic [7:0] third_port_data_ff, nxt_third_port_data;
  logic [7:0] first_port_direction_ff, nxt_first_port_direction;
  logic [7:0] first_port_pullup_enable_ff, nxt_first_port_pullup_enable;
  logic [5:0] second_port_direction_ff, nxt_second_port_direction;
  logic [7:0] third_port_direction_ff, nxt_third_port_direction;
  logic [7:0] rdata_ff, nxt_rdata;

  // synchronisers; stage one is read only by stage two
  logic [7:0] first_meta_ff, first_sync_ff;
  logic [5:0] second_meta_ff, second_sync_ff;
  logic [7:0] third_meta_ff, third_sync_ff;

  // pad drive registers
  pdef_pkg::pdef_pad8_t first_pad_ff, nxt_first_pad;
  pdef_pkg::pdef_pad6_t second_pad_ff, nxt_second_pad;
  pdef_pkg::pdef_pad8_t third_pad_ff, nxt_third_pad;

  logic wr_first_data, wr_second_data, wr_third_data;
  logic wr_first_dir, wr_first_pue, wr_second_dir, wr_third_dir;

  // address decode of the write strobe
  always_comb begin
    wr_first_data = bus_wr && (bus_addr == `PDEF_OFS_FIRST_DATA);
    wr_second_data = bus_wr && (bus_addr == `PDEF_OFS_SECOND_DATA);
    wr_third_data = bus_wr && (bus_addr == `PDEF_OFS_THIRD_DATA);
    wr_first_dir = bus_wr && (bus_addr == `PDEF_OFS_FIRST_DIR);
    wr_first_pue = bus_wr && (bus_addr == `PDEF_OFS_FIRST_PUE);
    wr_second_dir = bus_wr && (bus_addr == `PDEF_OFS_SECOND_DIR);
    wr_third_dir = bus_wr && (bus_addr == `PDEF_OFS_THIRD_DIR);
  end

  // data latches take every write, whatever the direction bits say
  always_comb begin
    nxt_first_port_data = wr_first_data ? bus_wdata : first_port_data_ff; // R4
    nxt_second_port_data = wr_second_data ?
      bus_wdata[`PDEF_SECOND_W-1:0] : second_port_data_ff; // R4 R8
    nxt_third_port_data = wr_third_data ? bus_wdata : third_port_data_ff; // R4
  end

  // no reset here: latch contents survive a reset
  always_ff @(posedge mclk) begin
    first_port_data_ff <= nxt_first_port_data; // R7
    second_port_data_ff <= nxt_second_port_data; // R7
    third_port_data_ff <= nxt_third_port_data; // R7
  end

  // direction and pullup enable registers
  always_comb begin
    nxt_first_port_direction = wr_first_dir ? bus_wdata : first_port_direction_ff;
    nxt_first_port_pullup_enable = wr_first_pue ? bus_wdata : first_port_pullup_enable_ff;
    nxt_second_port_direction = wr_second_dir ?
      bus_wdata[`PDEF_SECOND_W-1:0] : second_port_direction_ff; // R8
    nxt_third_port_direction = wr_third_dir ? bus_wdata : third_port_direction_ff;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      first_port_direction_ff <= `PDEF_RST_DIR8; // R2
      second_port_direction_ff <= `PDEF_RST_DIR6; // R2
      third_port_direction_ff <= `PDEF_RST_DIR8; // R2
      first_port_pullup_enable_ff <= `PDEF_RST_PUE;
    end else begin
      first_port_direction_ff <= nxt_first_port_direction;
      second_port_direction_ff <= nxt_second_port_direction;
      third_port_direction_ff <= nxt_third_port_direction;
      first_port_pullup_enable_ff <= nxt_first_port_pullup_enable;
    end
  end

  // two flops per pin before the read mux; no reset needed on a pure sampler
  always_ff @(posedge mclk) begin
    first_meta_ff <= first_pin_in;
    first_sync_ff <= first_meta_ff; // R16
    second_meta_ff <= second_pin_in;
    second_sync_ff <= second_meta_ff; // R16
    third_meta_ff <= third_pin_in;
    third_sync_ff <= third_meta_ff; // R16
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    nxt_rdata = `PDEF_RST_RDATA;
    if (bus_rd) begin
      unique case (bus_addr)
        `PDEF_OFS_FIRST_DATA:
          // direction chooses latch or pin even for spi-owned pins
          nxt_rdata = read_mix(first_port_direction_ff, first_port_data_ff,
                               first_sync_ff); // R3 R15
        `PDEF_OFS_SECOND_DATA:
          nxt_rdata = read_mix({2'h0, second_port_direction_ff},
                               {2'h0, second_port_data_ff},
                               {2'h0, second_sync_ff}); // R11 R9
        `PDEF_OFS_THIRD_DATA:
          nxt_rdata = read_mix(third_port_direction_ff, third_port_data_ff,
                               third_sync_ff); // R13
        `PDEF_OFS_FIRST_DIR: nxt_rdata = first_port_direction_ff;
        `PDEF_OFS_FIRST_PUE: nxt_rdata = first_port_pullup_enable_ff;
        `PDEF_OFS_SECOND_DIR: nxt_rdata = {2'h0, second_port_direction_ff};
        `PDEF_OFS_THIRD_DIR: nxt_rdata = third_port_direction_ff;
        default: nxt_rdata = `PDEF_RST_RDATA; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= `PDEF_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // pad drive; built from next-state values so a direction write and its
  // pullup/driver change land on the same edge, not one cycle apart
  logic [3:0] tim_own;

  always_comb begin
    tim_own = tim_owned(periph.timer_channel_edge_level_select);

    // first port: direction drives, spi takes over its owned pins
    nxt_first_pad.dout = nxt_first_port_data;
    nxt_first_pad.oe = nxt_first_port_direction; // R1
    for (int i = 0; i < 4; i++) begin
      if (periph.spi_own[i]) begin
        nxt_first_pad.dout[i] = periph.spi_dout[i]; // R15
        nxt_first_pad.oe[i] = periph.spi_oe[i]; // R15
      end
    end
    // pullup only on pins that are not driven
    nxt_first_pad.pu = nxt_first_port_pullup_enable & ~nxt_first_pad.oe; // R5 R6

    // second port: serial owns rx and tx while enabled
    nxt_second_pad.dout = nxt_second_port_data;
    nxt_second_pad.oe = nxt_second_port_direction; // R1
    if (periph.serial_interface_enable) begin
      nxt_second_pad.oe[`PDEF_SCI_RX_BIT] = 1'b0; // R9
      nxt_second_pad.dout[`PDEF_SCI_TX_BIT] = periph.sci_txd; // R9
      nxt_second_pad.oe[`PDEF_SCI_TX_BIT] = 1'b1; // R9
    end // else both pins stay under port control R10

    // third port: upper nibble handed to timer channels when selected
    nxt_third_pad.dout = nxt_third_port_data;
    nxt_third_pad.oe = nxt_third_port_direction; // R1
    for (int i = 0; i < 4; i++) begin
      if (tim_own[i]) begin
        nxt_third_pad.dout[`PDEF_TIM_LO_BIT + i] = periph.tim_dout[i]; // R12
        nxt_third_pad.oe[`PDEF_TIM_LO_BIT + i] = periph.tim_oe[i]; // R12
      end
    end
    nxt_third_pad.pu = 8'h00; // this port has no pullups
  end

  // pads come up undriven; the data seen before the first write is a don't-care
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_pad_ff <= '0; // R2
      second_pad_ff <= '0; // R2
      third_pad_ff <= '0; // R2
    end else begin
      first_pad_ff <= nxt_first_pad;
      second_pad_ff <= nxt_second_pad;
      third_pad_ff <= nxt_third_pad;
    end
  end

  assign bus_rdata = rdata_ff;
  assign first_pad = first_pad_ff;
  assign second_pad = second_pad_ff;
  assign third_pad = third_pad_ff;

endmodule

// File: pdef_consts.svh
// What this block does
// (R1) Direction bit 1 enables a pin's output driver; 0 makes it an input.
// (R2) Reset clears every direction bit of all three ports.
// (R3) First port data read returns latch where direction is 1, pin otherwise.
// (R4) Data writes always update latches; input pins read back the pin.
// (R5) First port input pin with pullup enable 1 gets internal pullup.
// (R6) Pullup is dropped whenever the pin is an output, following direction at once.
// (R7) Reset leaves all output data latches unchanged.
// (R8) Second port has six pins, six latch bits, six direction bits.
// (R9) Serial-owned second port pin ignores direction for drive, not for reads.
// (R10) Serial enable clear returns second port bits 1 and 0 to port control.
// (R11) Second port data read returns latch where direction is 1, pin otherwise.
// (R12) Third port bits 7..4 are timer channels 5..2 when their select enables them.
// (R13) Third port data read returns latch where direction is 1, pin otherwise.
// (R14) Software writes the latch before turning a pin to output.
// (R15) SPI-owned first port pins ignore direction for drive, not for reads.
// (R16) Pin levels pass a two-stage synchroniser before any read.
`ifndef PDEF_CONSTS_SVH
`define PDEF_CONSTS_SVH

`define PDEF_ADDR_W 16
`define PDEF_DATA_W 8
`define PDEF_FIRST_W 8
`define PDEF_SECOND_W 6
`define PDEF_THIRD_W 8

`define PDEF_OFS_FIRST_DATA 16'h0003
`define PDEF_OFS_SECOND_DATA 16'h0008
`define PDEF_OFS_THIRD_DATA 16'h0440
`define PDEF_OFS_FIRST_DIR 16'h0442
`define PDEF_OFS_FIRST_PUE 16'h0443
`define PDEF_OFS_SECOND_DIR 16'h0444
`define PDEF_OFS_THIRD_DIR 16'h0445

`define PDEF_RST_DIR8 8'h00
`define PDEF_RST_DIR6 6'h00
`define PDEF_RST_PUE 8'h00
`define PDEF_RST_RDATA 8'h00

// second port pin positions shared with the serial interface
`define PDEF_SCI_RX_BIT 1
`define PDEF_SCI_TX_BIT 0
// third port bits 7..4 carry timer channels 5..2
`define PDEF_TIM_LO_BIT 4

`endif

// File: pdef_pkg.sv
package pdef_pkg;

  // drive of one port towards the pad ring
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pu;
  } pdef_pad8_t;

  typedef struct packed {
    logic [5:0] dout;
    logic [5:0] oe;
  } pdef_pad6_t;

  // what the peripherals sharing the pins ask for
  typedef struct packed {
    logic serial_interface_enable;
    logic sci_txd;
    logic [3:0] spi_own;
    logic [3:0] spi_dout;
    logic [3:0] spi_oe;
    logic [7:0] timer_channel_edge_level_select;
    logic [3:0] tim_dout;
    logic [3:0] tim_oe;
  } pdef_periph_t;

endpackage

// File: pdef_gpio_chk.sv
`timescale 1ns/100ps
`include "pdef_consts.svh"
module pdef_gpio_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire pdef_pkg::pdef_periph_t periph,
  input wire logic [7:0] first_pin_in,
  input wire logic [5:0] second_pin_in,
  input wire logic [7:0] third_pin_in,
  input wire pdef_pkg::pdef_pad8_t first_pad,
  input wire pdef_pkg::pdef_pad6_t second_pad,
  input wire pdef_pkg::pdef_pad8_t third_pad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // direction writes while no peripheral holds the pins
  sequence s_dir1_wr;
    bus_wr && bus_addr == `PDEF_OFS_FIRST_DIR && periph.spi_own == 4'h0;
  endsequence
  sequence s_dir2_wr;
    bus_wr && bus_addr == `PDEF_OFS_SECOND_DIR && !periph.serial_interface_enable;
  endsequence
  sequence s_dir3_wr;
    bus_wr && bus_addr == `PDEF_OFS_THIRD_DIR && periph.timer_channel_edge_level_select == 8'h00;
  endsequence
  // reset itself must be seen, so this one is never disabled; the second reset edge
  // shows what the first one loaded, release may already reload latch data
  a_reset_pads: assert property (disable iff (1'b0) (rst ##1 rst) |-> first_pad == '0 &&
    second_pad == '0 && third_pad == '0) else $error("pads not cleared by reset");
  a_first_drive: assert property (s_dir1_wr |=> first_pad.oe == $past(bus_wdata))
    else $error("first port drive not from direction");
  a_second_drive: assert property (s_dir2_wr |=> second_pad.oe == $past(bus_wdata[5:0]))
    else $error("second port drive not from direction");
  a_third_drive: assert property (s_dir3_wr |=> third_pad.oe == $past(bus_wdata))
    else $error("third port drive not from direction");
  a_pull_gate: assert property ((first_pad.pu & first_pad.oe) == 8'h00)
    else $error("pullup on a driven pin");
  a_pull_enable: assert property (bus_wr && bus_addr == `PDEF_OFS_FIRST_PUE |=>
    first_pad.pu == ($past(bus_wdata) & ~first_pad.oe)) else $error("pullup mismatch");
  a_serial_owns: assert property (periph.serial_interface_enable |=> second_pad.oe[1:0] ==
    2'b01 && second_pad.dout[0] == $past(periph.sci_txd)) else $error("serial pins wrong");
  a_timer_owns: assert property (periph.timer_channel_edge_level_select[1:0] != 2'b00 |=>
    third_pad.oe[4] == $past(periph.tim_oe[0]) && third_pad.dout[4] == $past(periph.tim_dout[0]))
    else $error("timer pin wrong");
  a_spi_owns: assert property (periph.spi_own[0] |=> first_pad.oe[0] == $past(periph.spi_oe[0]))
    else $error("spi pin drive wrong");
endmodule
bind pdef_gpio pdef_gpio_chk pdef_gpio_chk_inst (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .periph(periph),
  .first_pin_in(first_pin_in), .second_pin_in(second_pin_in), .third_pin_in(third_pin_in),
  .first_pad(first_pad), .second_pad(second_pad), .third_pad(third_pad));

// File: pdef_pad_model.sv
`timescale 1ns/100ps
module pdef_pad_model (
  input wire logic mclk,
  input wire pdef_pkg::pdef_pad8_t first_pad,
  input wire pdef_pkg::pdef_pad6_t second_pad,
  input wire pdef_pkg::pdef_pad8_t third_pad,
  input wire logic [23:0] ext_val,
  input wire logic [23:0] ext_en,
  output logic [7:0] first_pin,
  output logic [5:0] second_pin,
  output logic [7:0] third_pin
);
  logic [7:0] flt_ff = 8'h00;
  logic [7:0] sec8;
  // floating pins toggle so a stale level can never pass
  always @(posedge mclk) flt_ff <= ~flt_ff;
  function automatic logic [7:0] lvl(input logic [7:0] oe, dout, en, v, pu, fl);
    return (oe & dout) | (~oe & en & v) | (~oe & ~en & (pu | fl));
  endfunction
  // pad driver wins, then outside circuit, then pullup
  assign first_pin = lvl(first_pad.oe, first_pad.dout, ext_en[7:0], ext_val[7:0],
    first_pad.pu, flt_ff);
  assign sec8 = lvl({2'b00, second_pad.oe}, {2'b00, second_pad.dout}, {2'b00, ext_en[13:8]},
    {2'b00, ext_val[13:8]}, 8'h00, flt_ff);
  assign second_pin = sec8[5:0];
  assign third_pin = lvl(third_pad.oe, third_pad.dout, ext_en[21:14], ext_val[21:14], 8'h00, flt_ff);
endmodule

// File: pdef_gpio_test.sv
`timescale 1ns/100ps
`include "pdef_consts.svh"
module pdef_gpio_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  pdef_pkg::pdef_periph_t periph = '0;
  pdef_pkg::pdef_pad8_t first_pad, third_pad;
  pdef_pkg::pdef_pad6_t second_pad;
  logic [7:0] first_pin, third_pin;
  logic [5:0] second_pin;
  logic [23:0] ext_val = 24'h000000;
  logic [23:0] ext_en = 24'hffffff;
  logic [15:0] lfsr = 16'hce5e;
  int err_count = 0;
  int cmp_count = 0;
  logic [15:0] dat_ofs [3] = '{`PDEF_OFS_FIRST_DATA, `PDEF_OFS_SECOND_DATA, `PDEF_OFS_THIRD_DATA};
  logic [15:0] dir_ofs [3] = '{`PDEF_OFS_FIRST_DIR, `PDEF_OFS_SECOND_DIR, `PDEF_OFS_THIRD_DIR};
  logic [7:0] msk [3] = '{8'hff, 8'h3f, 8'hff};
  logic [7:0] lat [3];
  always #12.5 mclk = ~mclk;
  pdef_gpio pdef_gpio_inst (.mclk(mclk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .periph(periph),
    .first_pin_in(first_pin), .second_pin_in(second_pin), .third_pin_in(third_pin),
    .first_pad(first_pad), .second_pad(second_pad), .third_pad(third_pad));
  pdef_pad_model pdef_pad_model_inst (.mclk(mclk), .first_pad(first_pad), .second_pad(second_pad),
    .third_pad(third_pad), .ext_val(ext_val), .ext_en(ext_en), .first_pin(first_pin),
    .second_pin(second_pin), .third_pin(third_pin));
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // latch where driven, pin level where input
  function automatic logic [7:0] exp_rd(input int p, input logic [7:0] d, l, input logic [23:0] e);
    logic [7:0] pin;
    pin = p == 0 ? e[7:0] : p == 1 ? {2'b00, e[13:8]} : e[21:14];
    return ((d & l) | (~d & pin)) & msk[p];
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    cmp_count++;
    if (bus_rdata !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, bus_rdata, e);
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog well beyond the roughly 1150 cycles the tests need
  initial begin
    repeat (8000) @(posedge mclk);
    err_count++;
    complete_run();
  end
  initial begin
    int p;
    logic [7:0] dv;
    logic [31:0] pr;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (p = 0; p < 3; p++) rd(dir_ofs[p], 8'h00);
    rd(`PDEF_OFS_FIRST_PUE, 8'h00);
    wr(16'h0446, 8'hff);
    rd(16'h0446, 8'h00);
    // random latch, direction and outside level across the three ports
    for (int n = 0; n < 90; n++) begin
      p = n % 3;
      lfsr = step(lfsr);
      lat[p] = lfsr[7:0] & msk[p];
      dv = lfsr[15:8];
      ext_val <= {lfsr[7:0], step(lfsr)};
      wr(dat_ofs[p], lat[p]);
      wr(dir_ofs[p], dv);
      repeat (3) @(posedge mclk);
      rd(dat_ofs[p], exp_rd(p, dv, lat[p], ext_val));
      rd(dir_ofs[p], dv & msk[p]);
    end
    // pulled-up inputs with nothing outside driving them
    ext_en <= 24'hffff00;
    lat[0] = 8'ha5;
    wr(`PDEF_OFS_FIRST_DATA, 8'ha5);
    wr(`PDEF_OFS_FIRST_PUE, 8'hff);
    wr(`PDEF_OFS_FIRST_DIR, 8'h0f);
    repeat (3) @(posedge mclk);
    rd(`PDEF_OFS_FIRST_DATA, 8'hf5);
    // latches must survive a second reset
    do_reset();
    for (p = 0; p < 3; p++) begin
      rd(dir_ofs[p], 8'h00);
      wr(dir_ofs[p], 8'hff);
      rd(dat_ofs[p], lat[p]);
    end
    // peripherals take pins; reads with direction set still show latches
    for (int n = 0; n < 40; n++) begin
      lfsr = step(lfsr);
      pr = {lfsr, step(lfsr)};
      periph <= pr[29:0]; // struct is 30 bits wide
      rd(dat_ofs[n % 3], lat[n % 3]);
    end
    complete_run();
  end
endmodule
